// ==== hw/lbs_cfg.svh ====
`ifndef LBS_CFG_SVH
`define LBS_CFG_SVH
`define LBS_NBANK 8
`define LBS_ROW_W 15
`define LBS_COL_W 10
`define LBS_DATA_W 32
`define LBS_MASK_W 4
`define LBS_MEM_DEPTH 256
`define LBS_TIM_W 8
`define LBS_CLK_NS 20
`define LBS_PRECHARGE_NS 18
`define LBS_ROW_TO_COL_NS 18
`define LBS_ACT_TO_ACT_NS 10
`define LBS_MODE_READ_CYC 4
`define LBS_MODE_WRITE_CYC 10
`define LBS_REFRESH_NS 210
`define LBS_BURST_CYC 4
`define LBS_CYC_UP(ns) ((((ns) + `LBS_CLK_NS - 1) / `LBS_CLK_NS) < 1 ? 1 : \
  (((ns) + `LBS_CLK_NS - 1) / `LBS_CLK_NS))
`define LBS_PRECHARGE_CYC `LBS_CYC_UP(`LBS_PRECHARGE_NS)
`define LBS_ROW_TO_COL_CYC `LBS_CYC_UP(`LBS_ROW_TO_COL_NS)
`define LBS_ACT_TO_ACT_CYC `LBS_CYC_UP(`LBS_ACT_TO_ACT_NS)
`define LBS_REFRESH_CYC `LBS_CYC_UP(`LBS_REFRESH_NS)
`endif

// ==== hw/lbs_pkg.sv ====
`include "lbs_cfg.svh"
package lbs_pkg;
  typedef enum logic [3:0] {
    LBS_NOP, LBS_ACT, LBS_RD, LBS_WR, LBS_RDA, LBS_WRA, LBS_PRE, LBS_PREA,
    LBS_REF, LBS_SREF, LBS_MRR, LBS_MRW, LBS_MRW_RESET
  } lbs_cmd_e;
  typedef enum logic [3:0] {
    LBS_B_POWERON, LBS_B_RESETTING, LBS_B_IDLE, LBS_B_ACTIVATING, LBS_B_ACTIVE,
    LBS_B_READING, LBS_B_WRITING, LBS_B_READING_AP, LBS_B_WRITING_AP,
    LBS_B_PRECHARGING, LBS_B_REFRESHING, LBS_B_MR_READING, LBS_B_MR_WRITING
  } lbs_bank_e;
  typedef logic [`LBS_TIM_W-1:0] lbs_tim_t;
  typedef logic [2:0] lbs_bank_t;
endpackage : lbs_pkg

// ==== hw/lbs_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lbs_cfg.svh"
interface lbs_link_if;
  import lbs_pkg::*;
  lbs_cmd_e cmd;
  lbs_bank_t bank;
  logic [`LBS_ROW_W-1:0] row;
  logic [`LBS_COL_W-1:0] col;
  logic [`LBS_DATA_W-1:0] wdata;
  logic [`LBS_MASK_W-1:0] write_mask;
  logic wvalid;
  logic [`LBS_DATA_W-1:0] rdata;
  logic rvalid;
  logic all_idle;
  logic illegal;
  modport ctrl (output cmd, bank, row, col, wdata, write_mask, wvalid,
    input rdata, rvalid, all_idle, illegal);
  modport dev (input cmd, bank, row, col, wdata, write_mask, wvalid,
    output rdata, rvalid, all_idle, illegal);
endinterface : lbs_link_if
`default_nettype wire

// ==== hw/lbs_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lbs_cfg.svh"
module lbs_bank (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lbs_pkg::lbs_cmd_e cmd,
  input wire logic hit,
  input wire logic all_idle_in,
  output lbs_pkg::lbs_bank_e state,
  output logic illegal
);
  import lbs_pkg::*;
  lbs_bank_e next_state;
  lbs_bank_e mr_return;
  lbs_tim_t timer;
  lbs_tim_t next_timer;
  logic next_illegal;
  logic act_ok;
  logic bursting;
  assign bursting = (state == LBS_B_READING) || (state == LBS_B_WRITING) ||
    (state == LBS_B_READING_AP) || (state == LBS_B_WRITING_AP);
  assign act_ok = (state == LBS_B_ACTIVE) || (bursting && timer == '0);
  // ------------------------------------------------------------
  // Next state per bank
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_timer = (timer != '0) ? timer - 1'b1 : timer;
    next_illegal = 1'b0;
    if (timer == '0) begin
      unique case (state)
        LBS_B_ACTIVATING, LBS_B_READING, LBS_B_WRITING: next_state = LBS_B_ACTIVE;
        LBS_B_READING_AP, LBS_B_WRITING_AP: begin
          next_state = LBS_B_PRECHARGING;
          next_timer = lbs_tim_t'(`LBS_PRECHARGE_CYC - 1);
        end
        LBS_B_PRECHARGING, LBS_B_REFRESHING, LBS_B_MR_WRITING, LBS_B_RESETTING:
          next_state = LBS_B_IDLE;
        LBS_B_MR_READING: begin
          next_state = mr_return;
          // Initialisation restarts, since the read cut into it
          if (mr_return == LBS_B_RESETTING) begin
            next_timer = lbs_tim_t'(`LBS_MODE_WRITE_CYC - 1);
          end
        end
        default: next_state = state;
      endcase
    end
    if (hit && cmd != LBS_NOP) begin
      unique case (cmd)
        LBS_ACT: if (state == LBS_B_IDLE) begin
          next_state = LBS_B_ACTIVATING;
          next_timer = lbs_tim_t'(`LBS_ROW_TO_COL_CYC - 1);
        end else next_illegal = 1'b1;
        LBS_RD, LBS_WR, LBS_RDA, LBS_WRA: if (act_ok) begin
          next_state = (cmd == LBS_RD) ? LBS_B_READING : (cmd == LBS_WR) ? LBS_B_WRITING :
            (cmd == LBS_RDA) ? LBS_B_READING_AP : LBS_B_WRITING_AP;
          next_timer = lbs_tim_t'(`LBS_BURST_CYC - 1);
        end else next_illegal = 1'b1;
        LBS_PRE, LBS_PREA: if (state == LBS_B_IDLE || state == LBS_B_ACTIVE ||
          state == LBS_B_PRECHARGING || (bursting && timer == '0)) begin
          next_state = LBS_B_PRECHARGING;
          next_timer = lbs_tim_t'(`LBS_PRECHARGE_CYC - 1);
        end else next_illegal = 1'b1;
        LBS_REF, LBS_SREF: if (all_idle_in) begin
          next_state = LBS_B_REFRESHING;
          next_timer = lbs_tim_t'(`LBS_REFRESH_CYC - 1);
        end else next_illegal = 1'b1;
        LBS_MRR: if (state == LBS_B_IDLE || state == LBS_B_ACTIVATING ||
          state == LBS_B_PRECHARGING || state == LBS_B_ACTIVE ||
          state == LBS_B_RESETTING) begin
          next_state = LBS_B_MR_READING;
          next_timer = lbs_tim_t'(`LBS_MODE_READ_CYC - 1);
        end else next_illegal = 1'b1;
        LBS_MRW, LBS_MRW_RESET: if (all_idle_in || state == LBS_B_POWERON ||
          state == LBS_B_RESETTING) begin
          // From power-on the reset command starts initialisation instead
          next_state = (state == LBS_B_POWERON && cmd == LBS_MRW_RESET) ? LBS_B_RESETTING :
            LBS_B_MR_WRITING;
          next_timer = lbs_tim_t'(`LBS_MODE_WRITE_CYC - 1);
        end else next_illegal = 1'b1;
        default: next_illegal = 1'b1;
      endcase
    end
  end
  // ------------------------------------------------------------
  // State record
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= LBS_B_POWERON;
      timer <= '0;
      illegal <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      illegal <= next_illegal;
    end
  end
  // Where a mode read returns: captured from the bank's state at the command
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mr_return <= LBS_B_IDLE;
    end else if (hit && cmd == LBS_MRR) begin
      unique case (state)
        LBS_B_RESETTING: mr_return <= LBS_B_RESETTING;
        LBS_B_ACTIVE, LBS_B_ACTIVATING: mr_return <= LBS_B_ACTIVE;
        default: mr_return <= LBS_B_IDLE;
      endcase
    end
  end
endmodule : lbs_bank
`default_nettype wire

// ==== hw/lbs_device.sv ====
// Function
// - Idle only after precharge interval elapses
// - Active after row-to-column delay, no access
// - Reading/writing until non-precharge burst ends
// - Refresh only all idle; mode write all idle, at power-on or while resetting
// - Only NOP during mode read/write windows, save mode read or mode write while resetting
// - Mode read from idle returns idle
// - Mode read while resetting returns reset
// - Mode read from active returns active
// - Mode write window then all idle
// - Activate-to-activate spacing between banks
// - Mode read accepted while row activating
// - Mode read accepted while precharging
// - Mode read next state follows bank state
// - Write only after read burst completes
// - Read only after write burst completes
// - Auto precharge lets other banks proceed
// - Precharge one bank or all banks
// - Reset is mode write, all idle
// - Mask bit high inhibits its byte of the write data beat
// - Precharge of idle bank still waits
`timescale 1ns/1ps
`default_nettype none
`include "lbs_cfg.svh"
module lbs_device (
  input wire logic clk_sys,
  input wire logic rst,
  lbs_link_if.dev link,
  output logic [`LBS_NBANK*4-1:0] bank_states,
  output logic all_idle,
  output logic illegal
);
  import lbs_pkg::*;
  lbs_bank_e st [`LBS_NBANK];
  logic [`LBS_NBANK-1:0] ill;
  logic [`LBS_NBANK-1:0] idle_v;
  logic [`LBS_DATA_W-1:0] mem [`LBS_MEM_DEPTH];
  logic [7:0] waddr;
  logic [7:0] raddr;
  logic [2:0] rbeats;
  logic [`LBS_DATA_W-1:0] rdata;
  logic rvalid;
  logic dev_all_idle;
  logic bank_cmd;
  assign bank_cmd = (link.cmd == LBS_ACT) || (link.cmd == LBS_RD) ||
    (link.cmd == LBS_WR) || (link.cmd == LBS_RDA) || (link.cmd == LBS_WRA) ||
    (link.cmd == LBS_PRE);
  // ------------------------------------------------------------
  // Bank records
  // ------------------------------------------------------------
  for (genvar b = 0; b < `LBS_NBANK; b++) begin : g_bank
    lbs_bank u_bank (
      .clk_sys(clk_sys),
      .rst(rst),
      .cmd(link.cmd),
      .hit(!bank_cmd || link.bank == 3'(b)),
      .all_idle_in(dev_all_idle),
      .state(st[b]),
      .illegal(ill[b])
    );
    assign idle_v[b] = (st[b] == LBS_B_IDLE);
  end
  assign dev_all_idle = &idle_v;
  // ------------------------------------------------------------
  // Write data with mask, read data return
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (link.wvalid) begin
      for (int i = 0; i < `LBS_MASK_W; i++) begin
        if (!link.write_mask[i]) mem[waddr][i*8 +: 8] <= link.wdata[i*8 +: 8];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waddr <= '0;
      raddr <= '0;
      rbeats <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
    end else begin
      if (link.cmd == LBS_WR || link.cmd == LBS_WRA) waddr <= {link.bank, link.col[4:0]};
      else if (link.wvalid) waddr <= waddr + 8'h01;
      if (link.cmd == LBS_RD || link.cmd == LBS_RDA) begin
        raddr <= {link.bank, link.col[4:0]};
        rbeats <= 3'(`LBS_BURST_CYC);
      end else if (rbeats != '0) begin
        raddr <= raddr + 8'h01;
        rbeats <= rbeats - 3'h1;
      end
      rvalid <= (rbeats != '0);
      rdata <= (rbeats != '0) ? mem[raddr] : '0;
    end
  end
  assign link.rdata = rdata;
  assign link.rvalid = rvalid;
  assign link.all_idle = all_idle;
  assign link.illegal = illegal;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      all_idle <= 1'b0;
      illegal <= 1'b0;
      bank_states <= '0;
    end else begin
      all_idle <= dev_all_idle;
      illegal <= |ill;
      for (int i = 0; i < `LBS_NBANK; i++) bank_states[i*4 +: 4] <= st[i];
    end
  end
endmodule : lbs_device
`default_nettype wire

// ==== hw/lbs_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lbs_cfg.svh"
module lbs_controller (
  input wire logic clk_sys,
  input wire logic rst,
  lbs_link_if.ctrl link,
  input wire logic req_valid,
  input wire lbs_pkg::lbs_cmd_e req_cmd,
  input wire lbs_pkg::lbs_bank_t req_bank,
  input wire logic [`LBS_ROW_W-1:0] req_row,
  input wire logic [`LBS_COL_W-1:0] req_col,
  input wire logic [`LBS_DATA_W-1:0] req_wdata,
  input wire logic [`LBS_MASK_W-1:0] req_mask,
  output logic req_ready,
  output logic [`LBS_DATA_W-1:0] rsp_data,
  output logic rsp_valid
);
  import lbs_pkg::*;
  lbs_cmd_e cmd;
  lbs_bank_t bank;
  logic [`LBS_ROW_W-1:0] row;
  logic [`LBS_COL_W-1:0] col;
  logic [`LBS_DATA_W-1:0] wdata;
  logic [`LBS_MASK_W-1:0] mask;
  logic wvalid;
  lbs_tim_t quiet;
  lbs_tim_t act_gap;
  logic [2:0] rd_left;
  logic [2:0] wr_left;
  logic ok;
  logic [1:0] recent;
  logic init_done;
  // ------------------------------------------------------------
  // Issue gating
  // ------------------------------------------------------------
  always_comb begin
    ok = (quiet == '0);
    if (req_cmd == LBS_ACT && act_gap != '0) ok = 1'b0;
    if ((req_cmd == LBS_WR || req_cmd == LBS_WRA) && rd_left != '0) ok = 1'b0;
    if ((req_cmd == LBS_RD || req_cmd == LBS_RDA) && wr_left != '0) ok = 1'b0;
    // The idle flag lags commands issued in the last two cycles, so wait until they show in it
    if ((req_cmd == LBS_REF || req_cmd == LBS_SREF || req_cmd == LBS_MRW) &&
      (!link.all_idle || recent != 2'b00)) ok = 1'b0;
    // Straight after power-on no bank is idle yet; only the reset may wake it
    if (req_cmd == LBS_MRW_RESET && (recent != 2'b00 || (!link.all_idle && init_done)))
      ok = 1'b0;
    // Beats of a write burst hold the bus; a new request waits so data stays in order
    if (wr_left > 3'h1) ok = 1'b0;
  end
  // ------------------------------------------------------------
  // Issue history for the idle checks
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      recent <= 2'b00;
      init_done <= 1'b0;
    end else begin
      recent <= {recent[0], req_valid && ok};
      if (req_valid && ok && (req_cmd == LBS_MRW || req_cmd == LBS_MRW_RESET)) begin
        init_done <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd <= LBS_NOP;
      bank <= '0;
      row <= '0;
      col <= '0;
      quiet <= '0;
      act_gap <= '0;
    end else begin
      cmd <= LBS_NOP;
      quiet <= (quiet != '0) ? quiet - 1'b1 : quiet;
      act_gap <= (act_gap != '0) ? act_gap - 1'b1 : act_gap;
      if (req_valid && ok) begin
        cmd <= req_cmd;
        bank <= req_bank;
        row <= req_row;
        col <= req_col;
        if (req_cmd == LBS_MRR) quiet <= lbs_tim_t'(`LBS_MODE_READ_CYC);
        if (req_cmd == LBS_MRW || req_cmd == LBS_MRW_RESET)
          quiet <= lbs_tim_t'(`LBS_MODE_WRITE_CYC);
        if (req_cmd == LBS_ACT) act_gap <= lbs_tim_t'(`LBS_ACT_TO_ACT_CYC);
      end
    end
  end
  // ------------------------------------------------------------
  // Burst tracking and write beats
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_left <= '0;
      wr_left <= '0;
      wvalid <= 1'b0;
      wdata <= '0;
      mask <= '0;
    end else begin
      rd_left <= (rd_left != '0) ? rd_left - 3'h1 : rd_left;
      wr_left <= (wr_left != '0) ? wr_left - 3'h1 : wr_left;
      wvalid <= (wr_left > 3'h1);
      if (req_valid && ok && (req_cmd == LBS_RD || req_cmd == LBS_RDA))
        rd_left <= 3'(`LBS_BURST_CYC + 1);
      if (req_valid && ok && (req_cmd == LBS_WR || req_cmd == LBS_WRA))
        wr_left <= 3'(`LBS_BURST_CYC + 1);
      if (req_valid && ok) begin
        wdata <= req_wdata;
        mask <= req_mask;
      end
    end
  end
  assign req_ready = ok;
  assign link.cmd = cmd;
  assign link.bank = bank;
  assign link.row = row;
  assign link.col = col;
  assign link.wdata = wdata;
  assign link.write_mask = mask;
  assign link.wvalid = wvalid;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsp_data <= '0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= link.rvalid;
      rsp_data <= link.rdata;
    end
  end
endmodule : lbs_controller
`default_nettype wire

// ==== sim/lbs_link_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lbs_cfg.svh"
module lbs_link_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lbs_pkg::lbs_cmd_e cmd,
  input wire logic wvalid,
  input wire logic rvalid,
  input wire logic all_idle,
  input wire logic illegal
);
  import lbs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----
  // Burst and window shapes
  // ----
  sequence s_rd;
    cmd inside {LBS_RD, LBS_RDA};
  endsequence
  sequence s_wr;
    cmd inside {LBS_WR, LBS_WRA};
  endsequence
  sequence s_mrw;
    cmd inside {LBS_MRW, LBS_MRW_RESET};
  endsequence
  a_rd_beats: assert property (s_rd |-> ##2 rvalid [*4])
    else $error("read burst beats missing");
  a_wr_beats: assert property (s_wr |-> ##1 wvalid [*4])
    else $error("write burst beats missing");
  a_wr_hold: assert property (s_wr |=> (cmd == LBS_NOP) [*4])
    else $error("command issued while write beats pending");
  a_rd_no_wr: assert property (s_rd |=> !(cmd inside {LBS_WR, LBS_WRA}) [*5])
    else $error("write issued during read burst");
  a_wr_no_rd: assert property (s_wr |=> !(cmd inside {LBS_RD, LBS_RDA}) [*5])
    else $error("read issued during write burst");
  a_mrr_quiet: assert property (cmd == LBS_MRR |=> (cmd == LBS_NOP) [*3])
    else $error("command inside mode read window");
  a_mrw_quiet: assert property (s_mrw |=> (cmd == LBS_NOP) [*8])
    else $error("command inside mode write window");
  // Wide bound: all_idle is registered and lags the bank state
  a_mrw_to_idle: assert property (s_mrw |-> ##[9:16] all_idle)
    else $error("mode write did not end all idle");
  a_mrr_to_idle: assert property (cmd == LBS_MRR && all_idle |-> ##[4:8] all_idle)
    else $error("mode read from idle did not return idle");
  a_ref_idle: assert property (cmd inside {LBS_REF, LBS_SREF, LBS_MRW} |-> all_idle)
    else $error("refresh or mode write while not idle");
  a_no_illegal: assert property (illegal == 1'b0)
    else $error("controller sent an illegal command");
endmodule : lbs_link_asserts
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lbs_cfg.svh"
module tb;
  import lbs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  lbs_cmd_e req_cmd = LBS_NOP;
  lbs_bank_t req_bank = 3'h0;
  logic [14:0] req_row = 15'h0;
  logic [9:0] req_col = 10'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] req_mask = 4'h0;
  logic req_ready;
  logic rsp_valid;
  logic [31:0] rsp_data;
  logic [31:0] rnd = 32'h734AE5C2;
  logic [31:0] bs;
  logic [31:0] bs2;
  logic [31:0] expq[$];
  int err_total = 0;
  int checked = 0;
  int ill_cnt = 0;
  lbs_link_if link();
  lbs_link_if link2();
  always #10 clk_sys = ~clk_sys;
  lbs_controller lbs_controller_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_row(req_row),
    .req_col(req_col), .req_wdata(req_wdata), .req_mask(req_mask), .req_ready(req_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid));
  lbs_device lbs_device_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
    .bank_states(bs), .all_idle(), .illegal());
  // Second device lets the bench break the command rules on purpose
  lbs_device lbs_device_inst_b (.clk_sys(clk_sys), .rst(rst), .link(link2),
    .bank_states(bs2), .all_idle(), .illegal());
  lbs_link_asserts lbs_link_asserts_inst (.clk_sys(clk_sys), .rst(rst), .cmd(link.cmd),
    .wvalid(link.wvalid), .rvalid(link.rvalid), .all_idle(link.all_idle),
    .illegal(link.illegal));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL time %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic rq(input lbs_cmd_e c, input lbs_bank_t b, input logic [9:0] a,
      input logic [31:0] d, input logic [3:0] m);
    int n;
    n = 0;
    rnd = lfsr(rnd);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_row <= rnd[14:0];
    req_col <= a;
    req_wdata <= d;
    req_mask <= m;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (n >= 100) chk(32'h0, 32'h1);
  endtask : rq
  task automatic idle(input int n);
    req_valid <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : idle
  // Polls, since the window length is the device's to keep
  task automatic wait_idle;
    int n;
    n = 0;
    idle(3);
    while (link.all_idle !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, link.all_idle}, 32'h1);
  endtask : wait_idle
  task automatic d2(input lbs_cmd_e c);
    link2.cmd <= c;
    @(posedge clk_sys);
  endtask : d2
  always @(posedge clk_sys) begin
    if (link2.illegal === 1'b1) ill_cnt++;
    if (rsp_valid === 1'b1) begin
      if (expq.size() > 0) chk(rsp_data, expq.pop_front());
      else chk(32'h0, 32'h1);
    end
  end
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] e;
    logic [9:0] a;
    logic [3:0] m;
    link2.cmd = LBS_NOP;
    link2.bank = 3'h0;
    link2.row = 15'h0;
    link2.col = 10'h0;
    link2.wdata = 32'h0;
    link2.write_mask = 4'h0;
    link2.wvalid = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    d2(LBS_ACT);
    d2(LBS_NOP);
    repeat (3) @(posedge clk_sys);
    chk(32'(ill_cnt), 32'h1);
    chk(bs2, {8{LBS_B_POWERON}});
    d2(LBS_MRW_RESET);
    d2(LBS_MRR);
    d2(LBS_NOP);
    repeat (6) @(posedge clk_sys);
    chk(bs2, {8{LBS_B_RESETTING}});
    repeat (10) @(posedge clk_sys);
    chk({31'h0, link2.all_idle}, 32'h1);
    d2(LBS_PRE);
    d2(LBS_ACT);
    d2(LBS_NOP);
    repeat (3) @(posedge clk_sys);
    chk(32'(ill_cnt), 32'h2);
    rq(LBS_MRW_RESET, 3'h0, 10'h0, 32'h0, 4'h0);
    wait_idle();
    chk(bs, {8{LBS_B_IDLE}});
    rq(LBS_MRR, 3'h0, 10'h0, 32'h0, 4'h0);
    wait_idle();
    for (int b = 0; b < 8; b++) rq(LBS_ACT, b[2:0], 10'h0, 32'h0, 4'h0);
    idle(4);
    chk(bs, {8{LBS_B_ACTIVE}});
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      w1 = rnd;
      rnd = lfsr(rnd);
      w2 = rnd;
      m = rnd[3:0];
      a = {rnd[9:5], 2'h0, rnd[2:0]};
      // Every beat repeats one word, so one merged word serves all four
      for (int k = 0; k < 4; k++) e[8*k+:8] = m[k] ? w1[8*k+:8] : w2[8*k+:8];
      repeat (4) expq.push_back(e);
      rq(LBS_WR, i[2:0], a, w1, 4'h0);
      rq(LBS_WR, i[2:0], a, w2, m);
      rq(i[0] ? LBS_RDA : LBS_RD, i[2:0], a, 32'h0, 4'h0);
    end
    idle(12);
    chk(bs, {{4{LBS_B_ACTIVE}}, LBS_B_IDLE, LBS_B_ACTIVE, LBS_B_IDLE, LBS_B_ACTIVE});
    rq(LBS_ACT, 3'h1, 10'h0, 32'h0, 4'h0);
    rq(LBS_MRR, 3'h0, 10'h0, 32'h0, 4'h0);
    idle(10);
    chk(bs, {{4{LBS_B_ACTIVE}}, LBS_B_IDLE, {3{LBS_B_ACTIVE}}});
    rq(LBS_PRE, 3'h2, 10'h0, 32'h0, 4'h0);
    rq(LBS_MRR, 3'h0, 10'h0, 32'h0, 4'h0);
    idle(10);
    chk(bs, {{4{LBS_B_ACTIVE}}, {2{LBS_B_IDLE}}, {2{LBS_B_ACTIVE}}});
    rq(LBS_PREA, 3'h0, 10'h0, 32'h0, 4'h0);
    wait_idle();
    rq(LBS_REF, 3'h0, 10'h0, 32'h0, 4'h0);
    wait_idle();
    rq(LBS_MRW, 3'h0, 10'h0, 32'h0, 4'h0);
    wait_idle();
    chk(32'(expq.size()), 32'h0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
